//--- src/async_timer_regs.svh
`ifndef ASYNC_TIMER_REGS_SVH
`define ASYNC_TIMER_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_COUNT 8'h00
`define ADDR_COMPARE 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_ASYNC_STATUS 8'h0C
`define ADDR_IRQ_ENABLE 8'h10
`define ADDR_FLAGS 8'h14
`define ADDR_GENERAL 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_CS_LSB 0
`define CTRL_MODE_LSB 4
`define ST_CONTROL_BUSY 0
`define ST_COMPARE_BUSY 1
`define ST_COUNT_BUSY 2
`define ST_EXT_CLOCK 3
`define ST_ASYNC_SEL 4
`define IRQ_OVERFLOW 0
`define IRQ_COMPARE 1
`define GEN_PRESCALER_RESET 1

// ----------------------------------------------------------------
// Reset values, timing counts and register slot indices
// ----------------------------------------------------------------
`define RESET_BYTE 8'h00
`define COMMIT_EDGES 2
`define FLAG_SYNC_CYCLES 3
`define REG_COUNT 0
`define REG_COMPARE 1
`define REG_CONTROL 2
`endif

//--- src/async_timer_pkg.sv
package async_timer_pkg;
   typedef enum logic [2:0] {
      CS_STOP = 3'h0,
      CS_DIRECT = 3'h1,
      CS_DIV8 = 3'h2,
      CS_DIV32 = 3'h3,
      CS_DIV64 = 3'h4,
      CS_DIV128 = 3'h5,
      CS_DIV256 = 3'h6,
      CS_DIV1024 = 3'h7
   } clock_select_type;
   typedef enum logic [1:0] {
      OUT_NONE = 2'h0,
      OUT_TOGGLE = 2'h1,
      OUT_CLEAR = 2'h2,
      OUT_SET = 2'h3
   } output_mode_type;
endpackage : async_timer_pkg

//--- src/async_timer.sv
`include "async_timer_regs.svh"

module async_timer
   import async_timer_pkg::*;
#(
   parameter int SYNC_STAGES = `FLAG_SYNC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_osc_input_pin,
   input wire logic sleep_active,
   input wire logic power_down,
   output logic compare_out,
   output logic osc_enable,
   output logic osc_pins_detached,
   output logic external_clock_enable,
   output logic wake_request
);
   initial begin
      if (SYNC_STAGES != `FLAG_SYNC_CYCLES) begin
         $error("SYNC_STAGES must be 3");
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic div_tick(input logic [2:0] sel,
                                     input logic src,
                                     input logic [9:0] pre);
      logic [9:0] mask;
      mask = 10'h000;
      unique case (clock_select_type'(sel))
         CS_STOP: mask = 10'h000;
         CS_DIRECT: mask = 10'h000;
         CS_DIV8: mask = 10'h007;
         CS_DIV32: mask = 10'h01F;
         CS_DIV64: mask = 10'h03F;
         CS_DIV128: mask = 10'h07F;
         CS_DIV256: mask = 10'h0FF;
         CS_DIV1024: mask = 10'h3FF;
      endcase
      div_tick = (sel != 3'h0) && src && ((pre & mask) == mask);
   endfunction : div_tick

   // ----------------------------------------------------------------
   // Oscillator pin synchroniser
   // ----------------------------------------------------------------
   logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
      end else begin
         osc_s1_ff <= timer_osc_input_pin;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
      end
   end
   // Rising edges can only be resolved while clk is over four times the
   // oscillator rate.
   logic osc_rise;
   assign osc_rise = osc_s2_ff && !osc_s3_ff;

   // ----------------------------------------------------------------
   // Timer state
   // ----------------------------------------------------------------
   logic [7:0] count_ff, nxt_count;
   logic [7:0] compare_ff, nxt_compare;
   logic [7:0] control_ff, nxt_control;
   logic [7:0] count_copy_ff, nxt_count_copy;
   logic [7:0] hold_ff [3], nxt_hold [3];
   logic [1:0] edges_ff [3], nxt_edges [3];
   logic [2:0] pend_ff, nxt_pend;
   logic async_sel_ff, nxt_async_sel;
   logic ext_clk_ff, nxt_ext_clk;
   logic [1:0] irq_en_ff, nxt_irq_en;
   logic [1:0] flags_ff, nxt_flags;
   logic [2:0] pipe_ff, nxt_pipe;
   logic [9:0] pre_ff, nxt_pre;
   logic cmp_out_ff, nxt_cmp_out;
   logic osc_en_ff, nxt_osc_en;
   logic detach_ff, nxt_detach;
   logic wake_ff, nxt_wake;
   logic armed_ff, nxt_armed;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;

   logic src_tick, pre_tick, wr_acc, rd_acc, cmp_event, ovf_event;
   logic mapped;

   // Source is the I/O clock by default; the select moves it to the pin.
   // Nothing is carried over on a switch, so contents may be corrupted.
   assign src_tick = async_sel_ff ? osc_rise : 1'b1;
   assign pre_tick = div_tick(control_ff[2:0], src_tick, pre_ff);
   assign wr_acc = psel && penable && pready_ff && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign mapped = (paddr <= `ADDR_GENERAL) && (paddr[1:0] == 2'h0);
   // A pending count or compare write blocks the match.
   assign cmp_event = pre_tick && (count_ff == compare_ff)
                      && !pend_ff[`REG_COUNT] && !pend_ff[`REG_COMPARE];
   assign ovf_event = pre_tick && (count_ff == 8'hFF)
                      && !pend_ff[`REG_COUNT];

   always_comb begin
      nxt_count = count_ff;
      nxt_compare = compare_ff;
      nxt_control = control_ff;
      nxt_hold = hold_ff;
      nxt_edges = edges_ff;
      nxt_pend = pend_ff;
      nxt_async_sel = async_sel_ff;
      nxt_ext_clk = ext_clk_ff;
      nxt_irq_en = irq_en_ff;
      nxt_flags = flags_ff;
      nxt_pre = pre_ff;
      nxt_cmp_out = cmp_out_ff;
      nxt_count_copy = count_copy_ff;
      nxt_pready = psel && !penable;
      nxt_pslverr = psel && !penable && !mapped;
      nxt_prdata = prdata_ff;

      if (pre_tick) begin
         nxt_count = count_ff + 8'h01;
      end
      if (src_tick) begin
         nxt_pre = pre_ff + 10'h001;
      end
      // Output pin follows the timer tick, not the CPU clock.
      if (cmp_event) begin
         unique case (output_mode_type'(control_ff[5:4]))
            OUT_NONE: nxt_cmp_out = cmp_out_ff;
            OUT_TOGGLE: nxt_cmp_out = !cmp_out_ff;
            OUT_CLEAR: nxt_cmp_out = 1'b0;
            OUT_SET: nxt_cmp_out = 1'b1;
         endcase
      end

      // Each register owns its own holding slot and edge count.
      for (int i = 0; i < 3; i++) begin
         if (pend_ff[i] && (!async_sel_ff || osc_rise)) begin
            nxt_edges[i] = edges_ff[i] + 2'h1;
            if (!async_sel_ff
                || edges_ff[i] == 2'(`COMMIT_EDGES - 1)) begin
               nxt_pend[i] = 1'b0;
               unique case (i)
                  `REG_COUNT: nxt_count = hold_ff[i];
                  `REG_COMPARE: nxt_compare = hold_ff[i];
                  default: nxt_control = hold_ff[i];
               endcase
            end
         end
      end
      // Read copy refreshes every clk in sync mode, and only on each rising oscillator edge in async mode.
      if (!async_sel_ff || osc_rise) begin
         nxt_count_copy = nxt_count;
      end

      if (async_sel_ff) begin
         if (pipe_ff[2]) begin
            nxt_flags[`IRQ_COMPARE] = 1'b1;
         end
      end else if (cmp_event) begin
         nxt_flags[`IRQ_COMPARE] = 1'b1;
      end
      if (ovf_event) begin
         nxt_flags[`IRQ_OVERFLOW] = 1'b1;
      end

      if (wr_acc) begin
         unique case (paddr)
            `ADDR_COUNT, `ADDR_COMPARE, `ADDR_CONTROL: begin
               nxt_hold[paddr[3:2]] = pwdata[7:0];
               nxt_edges[paddr[3:2]] = 2'h0;
               nxt_pend[paddr[3:2]] = 1'b1;
            end
            `ADDR_ASYNC_STATUS: begin
               nxt_async_sel = pwdata[`ST_ASYNC_SEL];
               nxt_ext_clk = pwdata[`ST_EXT_CLOCK];
            end
            `ADDR_IRQ_ENABLE: nxt_irq_en = pwdata[1:0];
            `ADDR_FLAGS: begin
               // Write one clears; a same-cycle event keeps the flag.
               if (pwdata[`IRQ_COMPARE] && !(async_sel_ff ? pipe_ff[2]
                                                           : cmp_event)) begin
                  nxt_flags[`IRQ_COMPARE] = 1'b0;
               end
               if (pwdata[`IRQ_OVERFLOW] && !ovf_event) begin
                  nxt_flags[`IRQ_OVERFLOW] = 1'b0;
               end
            end
            `ADDR_GENERAL: begin
               if (pwdata[`GEN_PRESCALER_RESET]) begin
                  nxt_pre = 10'h000;
               end
            end
            default: nxt_prdata = prdata_ff;
         endcase
      end

      // Losing the oscillator leaves the timer state undefined, so
      // pending transfers are dropped rather than half committed.
      if (power_down) begin
         nxt_pend = 3'h0;
      end

      if (rd_acc) begin
         unique case (paddr)
            `ADDR_COUNT: nxt_prdata = {24'h00_0000, count_copy_ff};
            `ADDR_COMPARE: nxt_prdata = {24'h00_0000, compare_ff};
            `ADDR_CONTROL: nxt_prdata = {24'h00_0000, control_ff};
            `ADDR_ASYNC_STATUS: nxt_prdata = {27'h000_0000, async_sel_ff,
               ext_clk_ff, pend_ff[`REG_COUNT], pend_ff[`REG_COMPARE],
               pend_ff[`REG_CONTROL]};
            `ADDR_IRQ_ENABLE: nxt_prdata = {30'h0000_0000, irq_en_ff};
            `ADDR_FLAGS: nxt_prdata = {30'h0000_0000, flags_ff};
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flag synchroniser, oscillator control and wake-up
   // ----------------------------------------------------------------
   always_comb begin
      nxt_pipe = {pipe_ff[1:0], async_sel_ff && cmp_event};
      nxt_osc_en = async_sel_ff && !power_down;
      nxt_detach = async_sel_ff;
      nxt_wake = wake_ff;
      nxt_armed = armed_ff;
      // The wake logic rearms on the first rising oscillator edge seen while awake.
      if (!sleep_active && osc_rise) begin
         nxt_armed = 1'b1;
         nxt_wake = 1'b0;
      end
      if (sleep_active && armed_ff && async_sel_ff && osc_rise
          && (|(flags_ff & irq_en_ff))) begin
         nxt_wake = 1'b1;
         nxt_armed = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= `RESET_BYTE;
         compare_ff <= `RESET_BYTE;
         control_ff <= `RESET_BYTE;
         count_copy_ff <= `RESET_BYTE;
         for (int i = 0; i < 3; i++) begin
            hold_ff[i] <= `RESET_BYTE;
            edges_ff[i] <= 2'h0;
         end
         pend_ff <= 3'h0;
         async_sel_ff <= 1'b0;
         ext_clk_ff <= 1'b0;
         irq_en_ff <= 2'h0;
         flags_ff <= 2'h0;
         pipe_ff <= 3'h0;
         pre_ff <= 10'h000;
         cmp_out_ff <= 1'b0;
         osc_en_ff <= 1'b0;
         detach_ff <= 1'b0;
         wake_ff <= 1'b0;
         armed_ff <= 1'b1;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         compare_ff <= nxt_compare;
         control_ff <= nxt_control;
         count_copy_ff <= nxt_count_copy;
         hold_ff <= nxt_hold;
         edges_ff <= nxt_edges;
         pend_ff <= nxt_pend;
         async_sel_ff <= nxt_async_sel;
         ext_clk_ff <= nxt_ext_clk;
         irq_en_ff <= nxt_irq_en;
         flags_ff <= nxt_flags;
         pipe_ff <= nxt_pipe;
         pre_ff <= nxt_pre;
         cmp_out_ff <= nxt_cmp_out;
         osc_en_ff <= nxt_osc_en;
         detach_ff <= nxt_detach;
         wake_ff <= nxt_wake;
         armed_ff <= nxt_armed;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign compare_out = cmp_out_ff;
   assign osc_enable = osc_en_ff;
   assign osc_pins_detached = detach_ff;
   assign external_clock_enable = ext_clk_ff;
   assign wake_request = wake_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence last_edge_s;
      async_sel_ff && pend_ff[0] && edges_ff[0] == 2'h1 && osc_rise;
   endsequence
   sequence calm_s;
      !wr_acc && !power_down;
   endsequence

   busy_on_write_a: assert property (wr_acc && paddr == `ADDR_COUNT
      && !power_down |=> pend_ff[0]) else $error("busy not set");
   commit_two_edges_a: assert property (last_edge_s and calm_s
      |=> !pend_ff[0] && count_ff == $past(hold_ff[0]))
      else $error("count not committed");
   hold_no_edge_a: assert property ((async_sel_ff && pend_ff[1]
      && !osc_rise) and calm_s |=> pend_ff[1])
      else $error("early commit");
   match_blocked_a: assert property ((pend_ff[0] || pend_ff[1])
      |-> !cmp_event) else $error("match while pending");
   flag_delay_a: assert property (async_sel_ff && cmp_event
      ##1 async_sel_ff[*3] |=> flags_ff[1])
      else $error("compare flag late");
   copy_stable_a: assert property (async_sel_ff && !osc_rise
      |=> $stable(count_copy_ff)) else $error("copy moved");
   osc_off_a: assert property (power_down |=> !osc_enable)
      else $error("oscillator on in power-down");
   detach_follow_a: assert property (##1 osc_pins_detached
      == $past(async_sel_ff)) else $error("pins not detached");
   prescale_clear_a: assert property (wr_acc && paddr == `ADDR_GENERAL
      && pwdata[1] |=> pre_ff == 10'h000)
      else $error("prescaler not reset");
   stop_sel_a: assert property (control_ff[2:0] == 3'h0 |-> !pre_tick)
      else $error("stopped timer ticked");
   default_src_a: assert property (!async_sel_ff
      && control_ff[2:0] == 3'h1 |-> pre_tick)
      else $error("source not I/O clock");
endmodule : async_timer

//--- verif/timer_osc_model.sv
// ----------------------------------------------------------------
// Crystal model
// ----------------------------------------------------------------
module timer_osc_model #(
   parameter realtime HALF_PERIOD = 210.0
) (
   input wire logic enable,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // A short period keeps the run brief; it stays above four clk cycles.
   initial pin = 1'b0;
   always begin
      if (enable === 1'b1) begin
         #(HALF_PERIOD) pin = ~pin;
      end else begin
         // A stopped crystal shows no stale level or edge.
         pin = 1'b0;
         @(enable);
      end
   end
endmodule : timer_osc_model

//--- verif/async_timer_clock_sync_prescaler_tb.sv
`include "async_timer_regs.svh"
module async_timer_clock_sync_prescaler_tb import async_timer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin;
   logic sleep_active, power_down, compare_out, osc_enable;
   logic osc_pins_detached, external_clock_enable, wake_request;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int compares = 0;
   int miscompares = 0;
   async_timer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_osc_input_pin(pin), .sleep_active(sleep_active),
      .power_down(power_down), .compare_out(compare_out),
      .osc_enable(osc_enable), .osc_pins_detached(osc_pins_detached),
      .external_clock_enable(external_clock_enable),
      .wake_request(wake_request));
   timer_osc_model u_osc (.enable(osc_enable), .pin(pin));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic results();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic hang(input string nm);
      miscompares++;
      $display("CHECK FAILED %s expected done seen timeout", nm);
      results();
   endtask : hang
   // pready is registered, so the falling edge shows its settled value.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang("pready");
      // The registered answer stands unchanged up to the sampling edge.
      q = prdata;
      err = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic get(input logic [7:0] a);
      logic er;
      apb(1'b0, a, 32'h0000_0000, er);
   endtask : get
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, e);
      chk("write error", 32'h0000_0000, {31'h0, e});
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      logic er;
      apb(1'b0, a, 32'h0000_0000, er);
      chk(nm, e, q);
   endtask : rd
   task automatic wait_pin(input logic v);
      int n;
      n = 0;
      while (pin !== v && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) hang("oscillator");
   endtask : wait_pin
   task automatic after_rise(input int c);
      wait_pin(1'b0);
      wait_pin(1'b1);
      repeat (c) @(posedge clk);
   endtask : after_rise
   task automatic wait_idle();
      int n;
      logic er;
      n = 0;
      do begin
         apb(1'b0, `ADDR_ASYNC_STATUS, 32'h0000_0000, er);
         n++;
      end while (q[2:0] !== 3'h0 && n < 100);
      if (n >= 100) hang("busy flags");
   endtask : wait_idle
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic e;
      for (int a = 0; a <= 24; a += 4) begin
         rd("reset value", a[7:0], 32'h0000_0000);
      end
      chk("pins detached", 32'h0, {31'h0, osc_pins_detached});
      apb(1'b0, 8'h1C, 32'h0000_0000, e);
      chk("unmapped", 32'h0000_0000, q);
      chk("slave error", 32'h1, {31'h0, e});
      $display("test reset done");
   endtask : t_reset
   task automatic t_prescale();
      int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
      logic [7:0] lo, hi;
      for (int cs = 0; cs < 8; cs++) begin
         wr(`ADDR_GENERAL, 32'h0000_0002);
         wr(`ADDR_COUNT, 32'h0000_0007);
         wr(`ADDR_CONTROL, cs);
         repeat (3 * divs[cs] + 4) @(posedge clk);
         wr(`ADDR_CONTROL, CS_STOP);
         get(`ADDR_COUNT);
         // Running edges are the wait plus three of bus overhead.
         lo = (cs == 0) ? 8'h07 : (cs == 1) ? 8'h11 : 8'h0A;
         hi = (cs == 0) ? 8'h07 : (cs == 1) ? 8'h11 : 8'h0B;
         chk("count in range", 32'h1,
             {31'h0, q[7:0] >= lo && q[7:0] <= hi});
      end
      $display("test prescale done");
   endtask : t_prescale
   task automatic t_async();
      wr(`ADDR_IRQ_ENABLE, 32'h0000_0000);
      wr(`ADDR_ASYNC_STATUS, 32'h0000_0018);
      repeat (2) @(posedge clk);
      chk("pins detached", 32'h1, {31'h0, osc_pins_detached});
      chk("osc enable", 32'h1, {31'h0, osc_enable});
      chk("ext clock", 32'h1, {31'h0, external_clock_enable});
      after_rise(6);
      wr(`ADDR_COMPARE, 32'h0000_005A);
      rd("busy set", `ADDR_ASYNC_STATUS, 32'h0000_001A);
      after_rise(5);
      rd("busy one edge", `ADDR_ASYNC_STATUS, 32'h0000_001A);
      after_rise(6);
      rd("busy cleared", `ADDR_ASYNC_STATUS, 32'h0000_0018);
      rd("compare", `ADDR_COMPARE, 32'h0000_005A);
      wr(`ADDR_COUNT, 32'h0000_0033);
      wr(`ADDR_COMPARE, 32'h0000_0044);
      wait_idle();
      after_rise(6);
      rd("compare kept", `ADDR_COMPARE, 32'h0000_0044);
      rd("count copy", `ADDR_COUNT, 32'h0000_0033);
      $display("test async done");
   endtask : t_async
   task automatic t_wake();
      int n;
      wr(`ADDR_IRQ_ENABLE, 32'h0000_0002);
      wr(`ADDR_COMPARE, 32'h0000_0004);
      wr(`ADDR_COUNT, 32'h0000_0000);
      wr(`ADDR_CONTROL, CS_DIRECT);
      wait_idle();
      wr(`ADDR_FLAGS, 32'h0000_0003);
      sleep_active <= 1'b1;
      n = 0;
      while (wake_request !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 1000) hang("wake request");
      @(posedge clk);
      sleep_active <= 1'b0;
      get(`ADDR_FLAGS);
      chk("compare flag", 32'h1, {31'h0, q[1]});
      wr(`ADDR_COMPARE, 32'h0000_0004);
      wait_idle();
      get(`ADDR_COUNT);
      chk("count advanced", 32'h1, {31'h0, q[7:0] >= 8'h05});
      power_down <= 1'b1;
      repeat (3) @(posedge clk);
      chk("osc stopped", 32'h0, {31'h0, osc_enable});
      power_down <= 1'b0;
      $display("test wake done");
   endtask : t_wake
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      sleep_active = 1'b0;
      power_down = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_prescale();
      t_async();
      t_wake();
      results();
   end
endmodule : async_timer_clock_sync_prescaler_tb
